// [src/pio_regs.svh]
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH
// Module addresses on the I/O bus.
`define PIO_ADDR_PORT1    4'h1
`define PIO_ADDR_PORT2    4'h2
`define PIO_ADDR_SYS      4'h3
`define PIO_ADDR_PORT4    4'h4
`define PIO_ADDR_PORT5    4'h5
`define PIO_ADDR_TIMER    4'h7
`define PIO_ADDR_AUXSW    4'h8
`define PIO_ADDR_SER_BUF  4'h9
`define PIO_ADDR_SER_STAT 4'hA
`define PIO_ADDR_VMON     4'hF
// Timer subport addresses.
`define PIO_SUB_T2C       4'h0
`define PIO_SUB_TIMER2_MODE_ONE      4'h1
`define PIO_SUB_TIMER2_MODE_TWO      4'h2
`define PIO_SUB_TIMER2_COMPARE_MODE      4'h3
`define PIO_SUB_TIMER2_COMPARE_ONE     4'h4
`define PIO_SUB_TIMER2_COMPARE_TWO     4'h5
`define PIO_SUB_TIMER1_CONTROL_ONE      4'h8
`define PIO_SUB_TIMER1_CONTROL_TWO      4'h9
`define PIO_SUB_WDC       4'hA
// Reset values; undefined bits are taken as zero.
`define PIO_RST_ONES4     4'hF
`define PIO_RST_ONES8     8'hFF
`define PIO_RST_ZERO4     4'h0
`define PIO_RST_PORT1     4'h9
`define PIO_RST_1X11      4'hB
`define PIO_RST_X111      4'h7
`define PIO_RD_UNDEF      4'h0
`endif

// [src/pio_pkg.sv]
package pio_pkg;
  // One bus cycle from the core: IN or OUT with its module address.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [3:0] data;
  } pio_req_t;

  // Timer block settings reached through the subport gateway.
  typedef struct packed {
    logic [3:0] t2_ctrl;
    logic [3:0] t2_mode_one;
    logic [3:0] t2_mode_two;
    logic [3:0] t2_cmp_mode;
    logic [3:0] t2_cmp_one;
    logic [7:0] t2_cmp_two;
    logic [3:0] t1_ctrl_one;
    logic [3:0] t1_ctrl_two;
    logic [3:0] wdog_ctrl;
  } pio_timer_cfg_t;

  typedef enum logic [1:0] {
    PIO_SUB_IDLE = 2'b01,
    PIO_SUB_SEL  = 2'b10
  } pio_sub_state_t;
endpackage

// [src/pio_port.sv]
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_port import pio_pkg::*; #(
  parameter int         PORT_W = 4,
  parameter logic [3:0] RST_V  = `PIO_RST_ONES4
) (
  input  wire logic              i_ref_clk,  // System clock.
  input  wire logic              i_rst,      // Synchronous reset.
  input  wire logic              i_wr,       // Data register write strobe.
  input  wire logic [PORT_W-1:0] i_wdata,    // Nibble to store.
  input  wire logic [PORT_W-1:0] i_drive,    // One per pin that drives.
  input  wire logic [PORT_W-1:0] i_pin,      // Pin levels.
  output logic      [PORT_W-1:0] o_pin,      // Pin output values.
  output logic      [PORT_W-1:0] o_pin_oe_n, // Low while a pin drives.
  output logic      [PORT_W-1:0] o_rd        // Pin levels for reads.
);
  logic [PORT_W-1:0] data_r;

  if (PORT_W != 4) begin : g_bad_width
    $error("pio_port serves four-bit ports only");
  end

  // Each pin has its own direction; reads see the pin even when driving.
  assign o_pin      = data_r;
  assign o_pin_oe_n = ~i_drive;
  assign o_rd       = i_pin;

  // The data latch holds the last written nibble.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      data_r <= RST_V;
    end else if (i_wr) begin
      data_r <= i_wdata;
    end
  end
endmodule

// [src/pio_decoder.sv]
`timescale 1ns/1ps
`include "pio_regs.svh"
// Overview of operation
// - Decode four-bit module address per IN/OUT.
// - Lone access hits the primary register.
// - Switch module write redirects next access to the named module auxiliary.
// - Byte registers move as successive nibble accesses.
// - Extended module holds sixteen indirect subports.
// - OUT subaddress first, then access subport.
// - Module seven is the timer subport gateway.
// - Timer compare two: byte, resets all ones.
// - Module two: port data, direction auxiliary.
// - Module one: port data, reset 1xx1.
// - Port four/five modes: byte, write-only, ones.
// - Module nine: serial buffers, control one auxiliary.
// - Module A: serial status/control, control two.
// - Module F: monitor control write, status read.
// - Ports 2, 4 and 5 are four pins, each own direction.
// - Data primary, control auxiliary, same address.
// - Byte control loads low nibble then high.
module pio_decoder import pio_pkg::*; #(
  parameter int PORT_W = 4
) (
  input  wire logic              i_ref_clk,      // System clock, 25 MHz.
  input  wire logic              i_rst,          // Synchronous reset.
  input  wire pio_req_t          i_io_req,       // IN/OUT request, one cycle.
  output logic      [3:0]        o_io_rdata,     // IN data, registered.
  output logic                   o_io_rvalid,    // IN data valid pulse.
  input  wire logic [PORT_W-1:0] i_port1_in,     // Port 1 input data.
  output logic      [3:0]        o_port1_data,   // Port 1 data latch.
  input  wire logic [PORT_W-1:0] i_port2_pin,    // Port 2 pin levels.
  output logic      [PORT_W-1:0] o_port2_pin,    // Port 2 outputs.
  output logic      [PORT_W-1:0] o_port2_oe_n,   // Port 2 enables, low drives.
  input  wire logic [PORT_W-1:0] i_port4_pin,    // Port 4 pin levels.
  output logic      [PORT_W-1:0] o_port4_pin,    // Port 4 outputs.
  output logic      [PORT_W-1:0] o_port4_oe_n,   // Port 4 enables, low drives.
  output logic      [7:0]        o_port4_mode,   // Port 4 mode byte.
  input  wire logic [PORT_W-1:0] i_port5_pin,    // Port 5 pin levels.
  output logic      [PORT_W-1:0] o_port5_pin,    // Port 5 outputs.
  output logic      [PORT_W-1:0] o_port5_oe_n,   // Port 5 enables, low drives.
  output logic      [7:0]        o_port5_mode,   // Port 5 mode byte.
  output logic      [3:0]        o_system_config,// System configuration.
  output logic      [3:0]        o_clock_manage, // Clock management.
  output logic                   o_wdog_kick,    // Watchdog kick pulse.
  output pio_timer_cfg_t         o_timer_cfg,    // Timer subport registers.
  output logic      [7:0]        o_serial_tx,    // Serial transmit byte.
  output logic                   o_serial_tx_ld, // Transmit byte complete.
  input  wire logic [7:0]        i_serial_rx,    // Serial receive byte.
  output logic      [3:0]        o_serial_ctl1,  // Serial control one.
  output logic      [3:0]        o_serial_ctl2,  // Serial control two.
  output logic      [3:0]        o_serial_sc,    // Serial status/control.
  input  wire logic [3:0]        i_serial_stat,  // Serial status bits.
  output logic      [3:0]        o_vmon_ctrl,    // Monitor control.
  input  wire logic [3:0]        i_vmon_stat     // Monitor status bits.
);
  if (PORT_W != 4) begin : g_bad_width
    $error("pio_decoder serves four-bit ports only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the request.

  logic           aux_pend_r;
  logic [3:0]     aux_mod_r;
  logic           nib_hi_r;
  logic [4:0]     nib_key_r;
  logic           nib_wr_r;
  logic [3:0]     sub_addr_r;
  pio_sub_state_t sub_state_r;
  pio_sub_state_t sub_state_nxt;
  logic [3:0]     port1_r;
  logic [3:0]     p2dir_r;
  logic [7:0]     p4mode_r;
  logic [7:0]     p5mode_r;
  pio_timer_cfg_t timer_r;
  logic [7:0]     stx_r;
  logic           stx_ld_r;
  logic [3:0]     sc_r;
  logic [3:0]     cm_r;
  logic           kick_r;
  logic [3:0]     serial_control_one_r;
  logic [3:0]     serial_control_two_r;
  logic [3:0]     serial_status_control_r;
  logic [3:0]     vmc_r;
  logic [3:0]     rdata_r;
  logic           rvalid_r;
  logic [3:0]     p2_rd;
  logic [3:0]     p4_rd;
  logic [3:0]     p5_rd;

  // A pin drives when its two mode bits are both zero.
  function automatic logic [3:0] pio_mode_drive(input logic [7:0] mode);
    logic [3:0] d;
    d = 4'h0;
    for (int i = 0; i < 4; i++) begin
      d[i] = ~(mode[2*i] | mode[2*i+1]);
    end
    return d;
  endfunction

  // Place a nibble in the low or high half of a byte.
  function automatic logic [7:0] pio_put_nib(input logic [7:0] b, input logic hi,
                                             input logic [3:0] n);
    return hi ? {n, b[3:0]} : {b[7:4], n};
  endfunction

  wire       acc      = i_io_req.rd | i_io_req.wr;
  wire [3:0] addr     = i_io_req.addr;
  wire [3:0] wd       = i_io_req.data;
  wire       aux_hit  = aux_pend_r && (aux_mod_r == addr);
  wire       is_prim  = acc && !aux_hit;
  wire       is_aux   = acc && aux_hit;
  wire       sub_live = (addr == `PIO_ADDR_TIMER) && (sub_state_r == PIO_SUB_SEL);
  wire       sub_acc  = acc && sub_live;
  wire       sub_set  = i_io_req.wr && (addr == `PIO_ADDR_TIMER) &&
                        (sub_state_r == PIO_SUB_IDLE);
  // Byte-wide targets: serial buffers, port modes, timer compare two.
  wire       byte_acc = (is_prim && addr == `PIO_ADDR_SER_BUF) ||
                        (is_aux && (addr == `PIO_ADDR_PORT4 || addr == `PIO_ADDR_PORT5)) ||
                        (sub_acc && sub_addr_r == `PIO_SUB_TIMER2_COMPARE_TWO);
  wire [4:0] key      = {aux_hit, addr};
  // An IN never pairs with an OUT, so a lone OUT after a read stays a low nibble.
  wire       hi_phase = nib_hi_r && (nib_key_r == key) && (nib_wr_r == i_io_req.wr);
  wire       byte_end = byte_acc && hi_phase;
  wire       unit_end = !byte_acc || byte_end;
  wire       aux_done = is_aux && unit_end;
  wire       sub_done = sub_acc && unit_end;

  // Write strobes per register.
  wire w        = i_io_req.wr;
  wire wp       = w && !aux_hit;
  wire wa       = w && aux_hit;
  wire w_port1  = wp && addr == `PIO_ADDR_PORT1;
  wire w_port2_data  = wp && addr == `PIO_ADDR_PORT2;
  wire w_p2dir  = wa && addr == `PIO_ADDR_PORT2;
  wire w_port4_data  = wp && addr == `PIO_ADDR_PORT4;
  wire w_port5_data  = wp && addr == `PIO_ADDR_PORT5;
  wire w_p4mode = wa && addr == `PIO_ADDR_PORT4;
  wire w_p5mode = wa && addr == `PIO_ADDR_PORT5;
  wire w_sc     = wp && addr == `PIO_ADDR_SYS;
  wire w_cm     = wa && addr == `PIO_ADDR_SYS;
  wire w_asw    = w && addr == `PIO_ADDR_AUXSW;
  wire w_stx    = wp && addr == `PIO_ADDR_SER_BUF;
  wire w_serial_control_one   = wa && addr == `PIO_ADDR_SER_BUF;
  wire w_serial_status_control   = wp && addr == `PIO_ADDR_SER_STAT;
  wire w_serial_control_two   = wa && addr == `PIO_ADDR_SER_STAT;
  wire w_vmc    = wp && addr == `PIO_ADDR_VMON;
  wire w_sub    = w && sub_live;
  wire r_kick   = i_io_req.rd && !aux_hit && addr == `PIO_ADDR_SYS;

  ////////////////////////////////////////////////////////////////////////////
  // Read selection; reserved and write-only places read as zero.

  wire [3:0] rx_nib = hi_phase ? i_serial_rx[7:4] : i_serial_rx[3:0];
  logic [3:0] rd_mux;
  always_comb begin
    rd_mux = `PIO_RD_UNDEF;
    if (is_prim && !sub_live) begin
      unique case (addr)
        `PIO_ADDR_PORT1:    rd_mux = i_port1_in;
        `PIO_ADDR_PORT2:    rd_mux = p2_rd;
        `PIO_ADDR_PORT4:    rd_mux = p4_rd;
        `PIO_ADDR_PORT5:    rd_mux = p5_rd;
        `PIO_ADDR_SER_BUF:  rd_mux = rx_nib;
        `PIO_ADDR_SER_STAT: rd_mux = i_serial_stat;
        `PIO_ADDR_VMON:     rd_mux = i_vmon_stat;
        default:            rd_mux = `PIO_RD_UNDEF;
      endcase
    end else if (is_aux && addr == `PIO_ADDR_SYS) begin
      rd_mux = cm_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary switch, nibble phase and subport sequencing.

  // The switch survives the low nibble of a byte so both halves land.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      aux_pend_r <= 1'b0;
      aux_mod_r  <= `PIO_RST_ONES4;
    end else if (w_asw) begin
      aux_pend_r <= 1'b1;
      aux_mod_r  <= wd;
    end else if (aux_done) begin
      aux_pend_r <= 1'b0;
    end
  end

  // Any other access restarts a half-done byte at its low nibble.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      nib_hi_r  <= 1'b0;
      nib_key_r <= 5'h00;
      nib_wr_r  <= 1'b0;
    end else if (acc) begin
      nib_hi_r  <= byte_acc && !hi_phase;
      nib_key_r <= key;
      nib_wr_r  <= i_io_req.wr;
    end
  end

  always_comb begin
    sub_state_nxt = sub_state_r;
    unique case (sub_state_r)
      PIO_SUB_IDLE: if (sub_set) sub_state_nxt = PIO_SUB_SEL;
      PIO_SUB_SEL:  if (sub_done) sub_state_nxt = PIO_SUB_IDLE;
      default:      sub_state_nxt = PIO_SUB_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sub_state_r <= PIO_SUB_IDLE;
      sub_addr_r  <= `PIO_RST_ZERO4;
    end else begin
      sub_state_r <= sub_state_nxt;
      if (sub_set) sub_addr_r <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer subport bank; reserved subports drop their writes.

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      timer_r <= '{`PIO_RST_ZERO4, `PIO_RST_ONES4, `PIO_RST_ONES4, `PIO_RST_ZERO4,
                   `PIO_RST_ONES4, `PIO_RST_ONES8, `PIO_RST_ONES4, `PIO_RST_X111,
                   `PIO_RST_ONES4};
    end else if (w_sub) begin
      unique case (sub_addr_r)
        `PIO_SUB_T2C:   timer_r.t2_ctrl     <= wd;
        `PIO_SUB_TIMER2_MODE_ONE:  timer_r.t2_mode_one <= wd;
        `PIO_SUB_TIMER2_MODE_TWO:  timer_r.t2_mode_two <= wd;
        `PIO_SUB_TIMER2_COMPARE_MODE:  timer_r.t2_cmp_mode <= wd;
        `PIO_SUB_TIMER2_COMPARE_ONE: timer_r.t2_cmp_one  <= wd;
        `PIO_SUB_TIMER2_COMPARE_TWO: timer_r.t2_cmp_two  <= pio_put_nib(timer_r.t2_cmp_two, hi_phase, wd);
        `PIO_SUB_TIMER1_CONTROL_ONE:  timer_r.t1_ctrl_one <= wd;
        `PIO_SUB_TIMER1_CONTROL_TWO:  timer_r.t1_ctrl_two <= wd;
        `PIO_SUB_WDC:   timer_r.wdog_ctrl   <= wd;
        default:        timer_r             <= timer_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain registers of the other modules.

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      port1_r  <= `PIO_RST_PORT1;
      p2dir_r  <= `PIO_RST_ONES4;
      p4mode_r <= `PIO_RST_ONES8;
      p5mode_r <= `PIO_RST_ONES8;
      sc_r     <= `PIO_RST_1X11;
      cm_r     <= `PIO_RST_ONES4;
      serial_control_one_r   <= `PIO_RST_ONES4;
      serial_control_two_r   <= `PIO_RST_ONES4;
      serial_status_control_r   <= `PIO_RST_1X11;
      vmc_r    <= `PIO_RST_ONES4;
    end else begin
      if (w_port1)  port1_r  <= wd;
      if (w_p2dir)  p2dir_r  <= wd;
      if (w_p4mode) p4mode_r <= pio_put_nib(p4mode_r, hi_phase, wd);
      if (w_p5mode) p5mode_r <= pio_put_nib(p5mode_r, hi_phase, wd);
      if (w_sc)     sc_r     <= wd;
      if (w_cm)     cm_r     <= wd;
      if (w_serial_control_one)   serial_control_one_r   <= wd;
      if (w_serial_control_two)   serial_control_two_r   <= wd;
      if (w_serial_status_control)   serial_status_control_r   <= wd;
      if (w_vmc)    vmc_r    <= wd;
    end
  end

  // The transmit load pulse marks the high nibble, so the byte is whole.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      stx_r    <= 8'h00;
      stx_ld_r <= 1'b0;
      kick_r   <= 1'b0;
      rdata_r  <= `PIO_RD_UNDEF;
      rvalid_r <= 1'b0;
    end else begin
      if (w_stx) stx_r <= pio_put_nib(stx_r, hi_phase, wd);
      stx_ld_r <= w_stx && hi_phase;
      kick_r   <= r_kick;
      rdata_r  <= i_io_req.rd ? rd_mux : rdata_r;
      rvalid_r <= i_io_req.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ports with their pin stages.

  pio_port #(.PORT_W(PORT_W), .RST_V(`PIO_RST_ONES4)) u_port2 (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr(w_port2_data), .i_wdata(wd),
    .i_drive(~p2dir_r), .i_pin(i_port2_pin), .o_pin(o_port2_pin),
    .o_pin_oe_n(o_port2_oe_n), .o_rd(p2_rd));
  pio_port #(.PORT_W(PORT_W), .RST_V(`PIO_RST_ONES4)) u_port4 (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr(w_port4_data), .i_wdata(wd),
    .i_drive(pio_mode_drive(p4mode_r)), .i_pin(i_port4_pin), .o_pin(o_port4_pin),
    .o_pin_oe_n(o_port4_oe_n), .o_rd(p4_rd));
  pio_port #(.PORT_W(PORT_W), .RST_V(`PIO_RST_ONES4)) u_port5 (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr(w_port5_data), .i_wdata(wd),
    .i_drive(pio_mode_drive(p5mode_r)), .i_pin(i_port5_pin), .o_pin(o_port5_pin),
    .o_pin_oe_n(o_port5_oe_n), .o_rd(p5_rd));

  // Outputs straight from registers.
  assign o_io_rdata      = rdata_r;
  assign o_io_rvalid     = rvalid_r;
  assign o_port1_data    = port1_r;
  assign o_port4_mode    = p4mode_r;
  assign o_port5_mode    = p5mode_r;
  assign o_system_config = sc_r;
  assign o_clock_manage  = cm_r;
  assign o_wdog_kick     = kick_r;
  assign o_timer_cfg     = timer_r;
  assign o_serial_tx     = stx_r;
  assign o_serial_tx_ld  = stx_ld_r;
  assign o_serial_ctl1   = serial_control_one_r;
  assign o_serial_ctl2   = serial_control_two_r;
  assign o_serial_sc     = serial_status_control_r;
  assign o_vmon_ctrl     = vmc_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  rd_answer_a: assert property (i_io_req.rd
    |=> o_io_rvalid && o_io_rdata == $past(rd_mux))
    else $error("IN not answered next cycle");
  asw_arm_a: assert property (w_asw |=> aux_pend_r && aux_mod_r == $past(wd))
    else $error("switch write did not arm auxiliary path");
  aux_once_a: assert property (aux_done && !w_asw |=> !aux_pend_r)
    else $error("auxiliary selection outlived its access");
  prim_only_a: assert property (w_port2_data |=> $stable(p2dir_r) && o_port2_pin == $past(wd))
    else $error("lone OUT disturbed the auxiliary register");
  dir_oe_a: assert property (w_p2dir |=> o_port2_oe_n == $past(wd))
    else $error("port 2 enables do not follow direction");
  mode_order_a: assert property (w_p4mode && !hi_phase ##1 w_p4mode
    |=> p4mode_r == {$past(wd), $past(wd, 2)})
    else $error("port 4 mode byte assembled wrongly");
  sub_seq_a: assert property (sub_set
    |=> sub_state_r == PIO_SUB_SEL && sub_addr_r == $past(wd))
    else $error("subaddress not taken");
  rsvd_read_a: assert property (i_io_req.rd && !sub_live && !aux_hit &&
    addr inside {4'hB, 4'hC, 4'hD, 4'hE} |=> o_io_rdata == `PIO_RD_UNDEF)
    else $error("reserved address read not zero");
  cmp_reset_a: assert property ($fell(i_rst) |-> timer_r.t2_cmp_two == `PIO_RST_ONES8)
    else $error("compare two reset wrong");
  tx_whole_a: assert property (o_serial_tx_ld |-> $past(w_stx, 2) && $past(w_stx))
    else $error("transmit load without two nibbles");

  aux_cov_c: cover property (w_asw ##1 w_p2dir);
  byte_cov_c: cover property (w_p5mode ##1 w_p5mode);
  sub_cov_c: cover property (sub_set ##1 w_sub && sub_addr_r == `PIO_SUB_TIMER2_COMPARE_TWO ##1 w_sub);
endmodule

// [sim/pio_core_model.sv]
`timescale 1ns/1ps
`include "pio_regs.svh"
// Stand-in for the 4-bit core: one IN or OUT per cycle, launched on the falling edge.
module pio_core_model import pio_pkg::*; (
  input  wire logic i_ref_clk, // System clock.
  output pio_req_t  o_io_req   // Request toward the decoder.
);
  // Quiet bus at time zero so reset sees no stray request.
  initial o_io_req = '0;

  // One bus cycle: the request stands across exactly one sampling edge.
  task automatic cyc(input logic r, input logic w, input logic [3:0] a, input logic [3:0] d);
    o_io_req = '{rd: r, wr: w, addr: a, data: d};
    @(negedge i_ref_clk);
  endtask

  // Auxiliary path: name the module to the switch, then access it.
  task automatic aux_wr(input logic [3:0] a, input logic [3:0] d);
    cyc(1'b0, 1'b1, `PIO_ADDR_AUXSW, a);
    cyc(1'b0, 1'b1, a, d);
  endtask

  // Bytes go low nibble then high, back to back; another access between them would restart the pairing, idle cycles would not.
  task automatic byte_wr(input logic [3:0] a, input logic [7:0] v);
    cyc(1'b0, 1'b1, a, v[3:0]);
    cyc(1'b0, 1'b1, a, v[7:4]);
  endtask
endmodule

// [sim/pio_decoder_bench.sv]
`timescale 1ns/1ps
module pio_decoder_bench import pio_pkg::*;;
  logic           ref_clk, rst, rvalid, kick, tx_ld;
  pio_req_t       req;
  pio_timer_cfg_t tcfg;
  logic [3:0]     rdata, p1_in, p1_data, sys_cfg, clk_mg, ctl1, ctl2, sc, sstat, vctl, vstat;
  logic [3:0]     p2_ext, p2_pin, p2_out, p2_oe_n, p4_ext, p4_pin, p4_out, p4_oe_n;
  logic [3:0]     p5_ext, p5_pin, p5_out, p5_oe_n;
  logic [7:0]     p4_mode, p5_mode, tx, rx;
  int             miscompares = 0;
  int             checks = 0;

  // Wire level of each pin: the driver wins while its enable is low, else the outside.
  assign p2_pin = (p2_oe_n & p2_ext) | (~p2_oe_n & p2_out);
  assign p4_pin = (p4_oe_n & p4_ext) | (~p4_oe_n & p4_out);
  assign p5_pin = (p5_oe_n & p5_ext) | (~p5_oe_n & p5_out);

  pio_core_model core (.i_ref_clk(ref_clk), .o_io_req(req));

  pio_decoder DUT (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_io_req(req), .o_io_rdata(rdata),
    .o_io_rvalid(rvalid), .i_port1_in(p1_in), .o_port1_data(p1_data),
    .i_port2_pin(p2_pin), .o_port2_pin(p2_out), .o_port2_oe_n(p2_oe_n),
    .i_port4_pin(p4_pin), .o_port4_pin(p4_out), .o_port4_oe_n(p4_oe_n),
    .o_port4_mode(p4_mode), .i_port5_pin(p5_pin), .o_port5_pin(p5_out),
    .o_port5_oe_n(p5_oe_n), .o_port5_mode(p5_mode), .o_system_config(sys_cfg),
    .o_clock_manage(clk_mg), .o_wdog_kick(kick), .o_timer_cfg(tcfg),
    .o_serial_tx(tx), .o_serial_tx_ld(tx_ld), .i_serial_rx(rx),
    .o_serial_ctl1(ctl1), .o_serial_ctl2(ctl2), .o_serial_sc(sc),
    .i_serial_stat(sstat), .o_vmon_ctrl(vctl), .i_vmon_stat(vstat)
  );

  // 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Counts every comparison; any difference is printed at once.
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    core.cyc(1'b0, 1'b1, a, d);
  endtask

  // The answer lands one cycle after the IN, so it is looked at on return.
  task automatic rd(input logic [3:0] a, input logic [3:0] e);
    core.cyc(1'b1, 1'b0, a, 4'h0);
    cmp({35'h0, rvalid, rdata}, {35'h0, 1'b1, e});
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Guard against a hung run; the whole run needs about ninety cycles.
  initial begin
    #(40 * 5000);
    miscompares++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    p1_in = 4'h3;
    p2_ext = 4'hA;
    p4_ext = 4'h6;
    p5_ext = 4'h9;
    rx = 8'h3C;
    sstat = 4'h5;
    vstat = 4'h2;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    // Reset state of the map.
    cmp({36'h0, p1_data}, 40'h9);
    cmp({24'h0, p4_mode, p5_mode}, 40'hFFFF);
    cmp(tcfg, 40'h0FF0FFFF7F);
    cmp({28'h0, p2_oe_n, p2_out, sc}, 40'hFFB);
    cmp({27'h0, kick, vctl, sys_cfg, clk_mg}, 40'hFBF);
    // Primary, then one auxiliary access, then primary again.
    wr(4'h2, 4'h5);
    rd(4'h2, 4'hA);
    core.aux_wr(4'h2, 4'h0);
    wr(4'h2, 4'h3);
    cmp({32'h0, p2_oe_n, p2_out}, 40'h03);
    rd(4'h2, 4'h3);
    // Byte mode registers; pin i drives only for code 00.
    wr(4'h8, 4'h4);
    core.byte_wr(4'h4, 8'h5C);
    wr(4'h4, 4'h1);
    cmp({24'h0, p4_mode, p4_oe_n, p4_out}, 40'h5CE1);
    wr(4'h8, 4'h5);
    core.byte_wr(4'h5, 8'h0F);
    cmp({28'h0, p5_mode, p5_oe_n}, 40'h0F3);
    rd(4'h5, 4'hD);
    // Timer subports, including every reserved one.
    wr(4'h7, 4'h5);
    core.byte_wr(4'h7, 8'hA4);
    for (int s = 0; s < 16; s++) begin
      if (s != 5) begin
        wr(4'h7, s[3:0]);
        wr(4'h7, ~s[3:0]);
      end
    end
    cmp(tcfg, 40'hFEDCBA4765);
    // Serial buffers back to back, then the auxiliary controls.
    rd(4'h9, 4'hC);
    rd(4'h9, 4'h3);
    core.byte_wr(4'h9, 8'h21);
    cmp({31'h0, tx_ld, tx}, 40'h121);
    core.aux_wr(4'h9, 4'h2);
    core.aux_wr(4'hA, 4'h6);
    wr(4'hA, 4'h1);
    rd(4'hA, 4'h5);
    wr(4'hF, 4'h8);
    rd(4'hF, 4'h2);
    wr(4'h1, 4'h6);
    rd(4'h1, 4'h3);
    cmp({24'h0, ctl1, ctl2, sc, vctl}, 40'h2618);
    // Module 3: configuration write, clock management both ways, watchdog kick on IN.
    wr(4'h3, 4'h5);
    core.aux_wr(4'h3, 4'h2);
    wr(4'h8, 4'h3);
    rd(4'h3, 4'h2);
    rd(4'h3, 4'h0);
    cmp({27'h0, kick, 4'h0, sys_cfg, clk_mg}, 40'h1052);
    // Reserved modules: writes vanish and reads come back as zero.
    for (int m = 0; m < 16; m++) begin
      if (m inside {0, 6, 11, 12, 13, 14}) begin
        wr(m[3:0], 4'h0);
        rd(m[3:0], 4'h0);
      end
    end
    cmp({28'h0, p1_data, vctl, p2_out}, 40'h683);
    core.cyc(1'b0, 1'b0, 4'h0, 4'h0);
    give_verdict();
  end
endmodule
